// ===== rrs_pkg.sv
// package for the rotate-right and set-file datapath
package rrs_pkg;
   // opcode fields, upper bits of the 16-bit instruction word
   localparam logic [5:0] OPC_ROT_RIGHT_CARRY = 6'h0C;
   localparam logic [5:0] OPC_ROT_RIGHT_PLAIN = 6'h10;
   localparam logic [6:0] OPC_SET_ALL_ONES = 7'h34;
   localparam int DEST_BIT = 9;
   localparam int BANK_BIT = 8;
   localparam logic [7:0] ALL_ONES = 8'hFF;
   localparam logic [7:0] RESET_ACCUM = 8'h00;
   localparam logic [3:0] ACCESS_BANK = 4'h0;
   localparam logic [3:0] RESET_BANK = 4'h0;
   // access bank: low half maps to bank 0, high half to the top bank
   localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
   localparam logic [7:0] ACCESS_SPLIT = 8'h80;

   typedef enum logic [1:0]
   {
      PH_DECODE = 2'b00,
      PH_READ = 2'b01,
      PH_PROCESS = 2'b11,
      PH_WRITE = 2'b10
   } rrs_phase_e;

   typedef enum logic [1:0]
   {
      OP_NONE = 2'h0,
      OP_RRC = 2'h1,
      OP_RRN = 2'h2,
      OP_SET = 2'h3
   } rrs_op_e;

   typedef struct packed
   {
      logic carry;
      logic negative;
      logic zero;
   } rrs_flags_s;

   typedef struct packed
   {
      logic we;
      logic [11:0] addr;
      logic [7:0] data;
   } rrs_file_wr_s;
endpackage : rrs_pkg

// ===== rrs_alu.sv
// combinational rotate and set unit
`timescale 1ns/1ps
module rrs_alu
(
   // operation and operand
   input wire rrs_pkg::rrs_op_e i_op,
   input wire logic [7:0] i_operand,
   input wire rrs_pkg::rrs_flags_s i_flags,
   // result
   output logic [7:0] o_result,
   output rrs_pkg::rrs_flags_s o_flags
);
   always_comb
   begin
      o_result = i_operand;
      o_flags = i_flags;
      case (i_op)
         rrs_pkg::OP_RRC:
         begin
            o_result = {i_flags.carry, i_operand[7:1]};
            o_flags.carry = i_operand[0];
            o_flags.negative = i_flags.carry;
            o_flags.zero = ({i_flags.carry, i_operand[7:1]} == 8'h00);
         end
         rrs_pkg::OP_RRN:
         begin
            o_result = {i_operand[0], i_operand[7:1]};
            o_flags.negative = i_operand[0];
            o_flags.zero = (i_operand == 8'h00);
         end
         rrs_pkg::OP_SET:
            o_result = rrs_pkg::ALL_ONES;
         default:
            o_result = i_operand;
      endcase
   end
endmodule : rrs_alu

// ===== rrs_core.sv
// four-phase execution of rotate-right and set-file instructions
`timescale 1ns/1ps
module rrs_core
(
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_reset,
   // instruction
   input wire logic i_instr_valid,
   input wire logic [15:0] i_instr,
   input wire logic [3:0] i_bank_select_reg,
   // file register read data
   input wire logic [7:0] i_file_rdata,
   // file register access
   output logic o_file_re,
   output logic [11:0] o_file_addr,
   output rrs_pkg::rrs_file_wr_s o_file_wr,
   // architectural state and handshake status
   output logic [7:0] o_working_accumulator,
   output rrs_pkg::rrs_flags_s o_flags,
   output logic o_busy,
   output logic o_done
);
   rrs_pkg::rrs_phase_e phase;
   rrs_pkg::rrs_op_e op;
   logic dest_select_bit;
   logic [11:0] addr;
   logic [7:0] operand;
   logic [7:0] result;
   rrs_pkg::rrs_flags_s next_flags;
   rrs_pkg::rrs_flags_s alu_flags;
   logic [7:0] alu_result;
   rrs_pkg::rrs_op_e instr_op;
   logic instr_supported;
   logic take;
   logic [11:0] instr_addr;

   function automatic rrs_pkg::rrs_op_e decode_op(input logic [15:0] instr);
      if (instr[15:10] == rrs_pkg::OPC_ROT_RIGHT_CARRY)
         return rrs_pkg::OP_RRC;
      else if (instr[15:10] == rrs_pkg::OPC_ROT_RIGHT_PLAIN)
         return rrs_pkg::OP_RRN;
      else if (instr[15:9] == rrs_pkg::OPC_SET_ALL_ONES)
         return rrs_pkg::OP_SET;
      return rrs_pkg::OP_NONE;
   endfunction : decode_op

   function automatic logic [11:0] form_addr(input logic a, input logic [3:0] bank, input logic [7:0] f);
      if (a)
         return {bank, f};
      else if (f < rrs_pkg::ACCESS_SPLIT)
         return {rrs_pkg::ACCESS_BANK, f};
      return {rrs_pkg::ACCESS_HIGH_BANK, f};
   endfunction : form_addr

   // field positions and carrier widths the datapath is built around
   if (rrs_pkg::DEST_BIT > 15 || rrs_pkg::DEST_BIT <= rrs_pkg::BANK_BIT)
   begin : g_bad_dest_bit
      $error("destination bit position out of range");
   end
   if (rrs_pkg::BANK_BIT < 8)
   begin : g_bad_bank_bit
      $error("bank bit overlaps the file address byte");
   end
   if ($bits(rrs_pkg::rrs_file_wr_s) != 21 || $bits(rrs_pkg::rrs_flags_s) != 3)
   begin : g_bad_carrier
      $error("file write port or flag carrier has the wrong width");
   end
   if (rrs_pkg::OPC_SET_ALL_ONES[6:1] == rrs_pkg::OPC_ROT_RIGHT_CARRY
      || rrs_pkg::OPC_SET_ALL_ONES[6:1] == rrs_pkg::OPC_ROT_RIGHT_PLAIN)
   begin : g_opcode_clash
      $error("set-file opcode overlaps a rotate opcode");
   end
   if (rrs_pkg::ACCESS_SPLIT == 8'h00)
   begin : g_bad_split
      $error("access bank split must leave a low half");
   end

   // one decode of the incoming word, shared by sequencer, capture and read port
   always_comb
   begin
      instr_op = decode_op(i_instr);
      instr_supported = (instr_op != rrs_pkg::OP_NONE);
      take = (phase == rrs_pkg::PH_DECODE) && i_instr_valid && instr_supported;
      instr_addr = form_addr(i_instr[rrs_pkg::BANK_BIT], i_bank_select_reg, i_instr[7:0]);
   end

   // flags come back from the architectural copy, so a back-to-back rotate sees the last write
   rrs_alu rrs_alu_i
   (
      .i_op(op),
      .i_operand(operand),
      .i_flags(o_flags),
      .o_result(alu_result),
      .o_flags(alu_flags)
   );

   // phase sequencer
   always_ff @(posedge i_core_clk)
   begin
      if (i_reset)
         phase <= rrs_pkg::PH_DECODE;
      else
         case (phase)
            rrs_pkg::PH_DECODE:
               if (take)
                  phase <= rrs_pkg::PH_READ;
            rrs_pkg::PH_READ:
               phase <= rrs_pkg::PH_PROCESS;
            rrs_pkg::PH_PROCESS:
               phase <= rrs_pkg::PH_WRITE;
            rrs_pkg::PH_WRITE:
               phase <= rrs_pkg::PH_DECODE;
            default:
               phase <= rrs_pkg::PH_DECODE;
         endcase
   end

   // decode capture; a refused word leaves the captured fields alone
   always_ff @(posedge i_core_clk)
   begin
      if (i_reset)
      begin
         op <= rrs_pkg::OP_NONE;
         dest_select_bit <= 1'b0;
         addr <= {rrs_pkg::RESET_BANK, 8'h00};
      end
      else if (take)
      begin
         op <= instr_op;
         if (instr_op == rrs_pkg::OP_SET)
            dest_select_bit <= 1'b1;
         else
            dest_select_bit <= i_instr[rrs_pkg::DEST_BIT];
         addr <= instr_addr;
      end
   end

   // operand read and processing
   // operand holds until the next read so the unit's output stays steady
   always_ff @(posedge i_core_clk)
   begin
      if (i_reset)
      begin
         operand <= 8'h00;
         result <= 8'h00;
         next_flags <= '0;
      end
      else if (phase == rrs_pkg::PH_READ)
         operand <= i_file_rdata;
      else if (phase == rrs_pkg::PH_PROCESS)
      begin
         result <= alu_result;
         next_flags <= alu_flags;
      end
   end

   // file register port
   always_ff @(posedge i_core_clk)
   begin
      if (i_reset)
      begin
         o_file_re <= 1'b0;
         o_file_addr <= 12'h000;
         o_file_wr <= '0;
      end
      else
      begin
         o_file_re <= take;
         if (take)
            o_file_addr <= instr_addr;
         // address and data load in the process phase whether or not the strobe is raised
         o_file_wr.we <= 1'b0;
         if (phase == rrs_pkg::PH_PROCESS)
         begin
            o_file_wr.we <= dest_select_bit;
            o_file_wr.addr <= addr;
            o_file_wr.data <= alu_result;
         end
      end
   end

   // accumulator and status write-back
   // set-file carries the flags through unchanged, so writing them back is harmless
   always_ff @(posedge i_core_clk)
   begin
      if (i_reset)
      begin
         o_working_accumulator <= rrs_pkg::RESET_ACCUM;
         o_flags <= '0;
      end
      else if (phase == rrs_pkg::PH_WRITE)
      begin
         if (!dest_select_bit)
            o_working_accumulator <= result;
         o_flags <= next_flags;
      end
   end

   // handshake status
   always_ff @(posedge i_core_clk)
   begin
      if (i_reset)
      begin
         o_busy <= 1'b0;
         o_done <= 1'b0;
      end
      else
      begin
         if (phase == rrs_pkg::PH_DECODE)
            o_busy <= take;
         else
            o_busy <= (phase != rrs_pkg::PH_WRITE);
         o_done <= (phase == rrs_pkg::PH_WRITE);
      end
   end
endmodule : rrs_core

// ===== rrs_core_checker.sv
// assertion checker for rrs_core
`timescale 1ns/1ps
module rrs_core_checker
(
   // inputs
   input wire logic i_core_clk,
   input wire logic i_reset,
   input wire logic i_instr_valid,
   input wire logic [15:0] i_instr,
   input wire logic [3:0] i_bank_select_reg,
   input wire logic [7:0] i_file_rdata,
   // outputs
   input wire logic o_file_re,
   input wire logic [11:0] o_file_addr,
   input wire rrs_pkg::rrs_file_wr_s o_file_wr,
   input wire logic [7:0] o_working_accumulator,
   input wire rrs_pkg::rrs_flags_s o_flags,
   input wire logic o_busy,
   input wire logic o_done
);
   wire logic set_op = i_instr[15:9] == rrs_pkg::OPC_SET_ALL_ONES;
   wire logic plain = i_instr[15:10] == rrs_pkg::OPC_ROT_RIGHT_PLAIN;
   wire logic rot = plain || i_instr[15:10] == rrs_pkg::OPC_ROT_RIGHT_CARRY;
   wire logic take = !o_busy && i_instr_valid && (set_op || rot);
   wire logic wr_op = set_op || i_instr[9];
   wire logic carry = o_flags.carry;
   wire logic [11:0] addr = {i_instr[8] ? i_bank_select_reg : {4{i_instr[7]}}, i_instr[7:0]};
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_reset);
   sequence busy_run;
      o_busy [*3] ##1 !o_busy;
   endsequence
   a_read_addr: assert property (take |=> o_file_re && o_file_addr == $past(addr))
      else $error("bad read address");
   a_busy_span: assert property (take |=> busy_run)
      else $error("bad busy span");
   a_done_time: assert property (take |-> ##4 o_done)
      else $error("late done");
   a_write_slot: assert property (take |-> ##3 o_file_wr.we == $past(wr_op, 3))
      else $error("bad write strobe");
   a_set_ones: assert property (take && set_op |-> ##3 o_file_wr.data == rrs_pkg::ALL_ONES)
      else $error("set data wrong");
   a_set_flags: assert property (take && set_op |-> ##4 o_flags == $past(o_flags, 4))
      else $error("set changed flags");
   a_carry_kept: assert property (take && plain |-> ##4 carry == $past(carry, 4))
      else $error("carry changed");
   a_acc_kept: assert property (take && wr_op |-> ##4 o_working_accumulator == $past(o_working_accumulator, 4))
      else $error("accumulator changed");
endmodule : rrs_core_checker

bind rrs_core rrs_core_checker rrs_core_checker_i (.*);

// ===== tb_rrs_core.sv
// self-checking bench for rrs_core
`timescale 1ns/1ps
module tb_rrs_core;
   logic i_core_clk = 1'h0;
   logic i_reset = 1'h1;
   logic i_instr_valid = 1'h0;
   logic [15:0] i_instr = 16'h0;
   logic [3:0] i_bank_select_reg = 4'h0;
   logic [7:0] i_file_rdata = 8'h0;
   logic o_file_re, o_busy, o_done;
   logic [11:0] o_file_addr;
   logic [7:0] o_working_accumulator;
   rrs_pkg::rrs_file_wr_s o_file_wr;
   rrs_pkg::rrs_flags_s o_flags;
   logic [11:0] aq[$];
   logic [19:0] wq[$];
   logic [10:0] dq[$];
   logic [31:0] rs = 32'h34;
   logic [7:0] acc = 8'h0;
   logic [7:0] res;
   logic [2:0] fl = 3'h0;
   int mismatches = 0;
   int check_count = 0;
   rrs_core rrs_core_i (.*);
   initial forever #20 i_core_clk = ~i_core_clk;
   function logic [31:0] xs(logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction : xs
   task check(logic [31:0] seen, logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("BAD %0t seen %h exp %h", $time, seen, exp);
      end
   endtask : check
   task close_out;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : close_out
   // back to back: next instruction is taken on the done edge
   task run(logic [1:0] op, logic d, logic a, logic [7:0] f, logic [3:0] b, logic [7:0] v);
      logic [11:0] ad;
      ad = {a ? b : {4{f[7]}}, f};
      i_instr = op == 2'h2 ? {rrs_pkg::OPC_SET_ALL_ONES, a, f}
         : {op[0] ? rrs_pkg::OPC_ROT_RIGHT_PLAIN : rrs_pkg::OPC_ROT_RIGHT_CARRY, d, a, f};
      i_bank_select_reg = b;
      i_file_rdata = v;
      i_instr_valid = 1'h1;
      res = op == 2'h2 ? 8'hFF : {op[0] ? v[0] : fl[2], v[7:1]};
      if (op != 2'h2)
         fl = {op[0] ? fl[2] : v[0], res[7], res == 8'h0};
      if (op == 2'h2 || d)
         wq.push_back({ad, res});
      else
         acc = res;
      aq.push_back(ad);
      dq.push_back({acc, fl});
      @(posedge i_core_clk);
      #1;
      // a different word while busy must be ignored
      i_instr = i_instr ^ 16'h0300;
      i_bank_select_reg = ~b;
      repeat (3) @(posedge i_core_clk);
      #1;
   endtask : run
   always @(posedge i_core_clk)
   begin
      if (o_file_re) check(o_file_addr, aq.pop_front());
      if (o_file_wr.we) check({o_file_wr.addr, o_file_wr.data}, wq.pop_front());
      if (o_done) check({o_working_accumulator, o_flags}, dq.pop_front());
   end
   initial
   begin
      repeat (10) @(posedge i_core_clk);
      #1;
      i_reset = 1'h0;
      run(2'h0, 1'h0, 1'h0, 8'h20, 4'h3, 8'hE6);
      repeat (80)
      begin
         rs = xs(rs);
         run(rs[1:0] % 2'h3, rs[2], rs[3], rs[15:8], rs[7:4], rs[23:16]);
      end
      i_instr = 16'hFFFF;
      repeat (6) @(posedge i_core_clk);
      #1;
      check(o_busy, 1'h0);
      check(aq.size() + wq.size() + dq.size(), 32'h0);
      close_out();
   end
   initial
   begin
      #40000;
      mismatches++;
      close_out();
   end
endmodule : tb_rrs_core
